/* cpsd_pkg.sv */
// constants for the four-port secondary select decoder
// assumes one clock domain and host address lines sampled on clk
`default_nettype none
package cpsd_pkg;
  localparam int unsigned BASE_W      = 6;
  localparam int unsigned IDX_W       = 5;
  localparam int unsigned LATCH_W     = 8;
  localparam int unsigned LATCH_IDX_W = 3;
  localparam int unsigned DIAL_IN_W   = 5;
  localparam int unsigned SW_W        = 2;
  localparam int unsigned CTRL_BITS   = 32;
  // bit select line carrying address line A10
  localparam int unsigned A10_POS     = 4;
  localparam logic [LATCH_W-1:0] LATCH_CLEAR = 8'h00;
  // port A output latch bit map
  localparam int unsigned LED_BIT     = 0;
  localparam int unsigned DTR_BIT     = 1;
  // port A modem input mux map
  localparam logic [LATCH_IDX_W-1:0] MUX_DSR = 3'h0;
  localparam logic [LATCH_IDX_W-1:0] MUX_RI  = 3'h1;
  localparam logic [LATCH_IDX_W-1:0] MUX_SW0 = 3'h2;
  localparam logic [LATCH_IDX_W-1:0] MUX_SW1 = 3'h3;
endpackage : cpsd_pkg
`default_nettype wire

/* cpsd_addr_latch.sv */
// eight-bit addressable output latch
// assumes sel_n already includes the bit-write strobe
`default_nettype none
module cpsd_addr_latch
  import cpsd_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   clear,
  input  wire logic                   sel_n,
  input  wire logic [LATCH_IDX_W-1:0] index,
  input  wire logic                   data,
  output logic      [LATCH_W-1:0]     q
);
  always_ff @(posedge clk) begin
    if (clear) begin
      q <= LATCH_CLEAR;
    end else if (!sel_n) begin
      q[index] <= data;
    end
  end
endmodule : cpsd_addr_latch
`default_nettype wire

/* cpsd_bit_mux.sv */
// eight-to-one bit input selector
// assumes a disabled selector returns zero
`default_nettype none
module cpsd_bit_mux
  import cpsd_pkg::*;
(
  input  wire logic [LATCH_W-1:0]     din,
  input  wire logic [LATCH_IDX_W-1:0] index,
  input  wire logic                   sel_n,
  output logic                        bit_out
);
  assign bit_out = !sel_n && din[index];
endmodule : cpsd_bit_mux
`default_nettype wire

/* cpsd_decoder.sv */
// secondary select decoder and bit-input return for four serial ports
// assumes host address, strobe and switch inputs are synchronous to clk
// Contract
// R1 - any primary select raises port enable valid
// R2 - any primary select enables return buffer
// R3 - no select: return off, selects high
// R4 - B-D select needs valid, primary, address term
// R5 - A9- high selects that port's controller
// R6 - A9- low selects that port's misc target
// R7 - port A idle keeps its selects high
// R8 - port A, A9- low enables lower group
// R9 - strobe and A10 high select dialer latch
// R10 - A10 high, strobe low: dialer input mux
// R11 - A10 low, strobe low: modem input mux
// R12 - A10 low, strobe high: LED latch
// R13 - port A, A9- high selects controller
// R14 - controller window 32 bits on A10-A14
// R15 - controller wiring: selects, enable, serial lines
// R16 - port A latch drives LED and DTR
// R17 - port A mux returns DSR, RI, switches
// R18 - primary select on A3-A8 base match
// R19 - I/O clear empties output latches
// R20 - selects combinational, one target per port
`default_nettype none
module cpsd_decoder
  import cpsd_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 io_clear_n,
  input  wire logic [BASE_W-1:0]    addr_base,
  input  wire logic                 addr_a9_n,
  input  wire logic [IDX_W-1:0]     bit_select_lines,
  input  wire logic                 bit_write_strobe,
  input  wire logic                 serial_bit_out,
  input  wire logic [BASE_W-1:0]    base_sw_a,
  input  wire logic [BASE_W-1:0]    base_sw_b,
  input  wire logic [BASE_W-1:0]    base_sw_c,
  input  wire logic [BASE_W-1:0]    base_sw_d,
  input  wire logic                 ctrl_bit_in_a,
  input  wire logic                 ctrl_bit_in_b,
  input  wire logic                 ctrl_bit_in_c,
  input  wire logic                 ctrl_bit_in_d,
  input  wire logic                 misc_bit_in_b,
  input  wire logic                 misc_bit_in_c,
  input  wire logic                 misc_bit_in_d,
  input  wire logic                 modem_dsr_a_n,
  input  wire logic                 modem_ri_a_n,
  input  wire logic [SW_W-1:0]      switch_data_a,
  input  wire logic [DIAL_IN_W-1:0] dialer_in,
  output logic                      primary_sel_port_a,
  output logic                      primary_sel_port_b,
  output logic                      primary_sel_port_c,
  output logic                      primary_sel_port_d,
  output logic                      port_enable_valid,
  output logic                      return_enable_n,
  output logic                      serial_bit_in,
  output logic                      serial_bit_in_oe,
  output logic [IDX_W-1:0]          ctrl_bit_select,
  output logic                      ctrl_cs_port_a_n,
  output logic                      ctrl_cs_port_b_n,
  output logic                      ctrl_cs_port_c_n,
  output logic                      ctrl_cs_port_d_n,
  output logic                      misc_sel_port_b_n,
  output logic                      misc_sel_port_c_n,
  output logic                      misc_sel_port_d_n,
  output logic                      lower_group_enable_n,
  output logic                      modem_in_mux_sel_n,
  output logic                      dialer_in_mux_sel_n,
  output logic                      led_latch_sel_n,
  output logic                      dialer_out_latch_sel_n,
  output logic [LATCH_W-1:0]        port_a_latch,
  output logic [LATCH_W-1:0]        dialer_latch,
  output logic                      led_a,
  output logic                      dtr_a
);
  import cpsd_pkg::*;

  // three-input nand of the port decoder
  function automatic logic sel_nand(input logic valid, input logic prim, input logic term);
    sel_nand = !(valid && prim && term);
  endfunction : sel_nand

  logic                   a10;
  logic [LATCH_IDX_W-1:0] sub_index;
  logic                   latch_clear;
  logic                   modem_bit;
  logic                   dialer_bit;
  logic [LATCH_W-1:0]     modem_din;
  logic [LATCH_W-1:0]     dialer_din;

  assign a10       = bit_select_lines[A10_POS];
  assign sub_index = bit_select_lines[LATCH_IDX_W-1:0];

  // base address compare per port
  assign primary_sel_port_a = (addr_base == base_sw_a); // R18
  assign primary_sel_port_b = (addr_base == base_sw_b); // R18
  assign primary_sel_port_c = (addr_base == base_sw_c); // R18
  assign primary_sel_port_d = (addr_base == base_sw_d); // R18

  // enable validator
  assign port_enable_valid = primary_sel_port_a || primary_sel_port_b
                          || primary_sel_port_c || primary_sel_port_d; // R1
  assign return_enable_n   = !port_enable_valid; // R2 R3
  assign serial_bit_in_oe  = !return_enable_n; // R2 R3

  // controller bit select lines, A10 first
  assign ctrl_bit_select = bit_select_lines; // R14 R15

  // ports B, C, D decoder
  assign ctrl_cs_port_b_n  = sel_nand(port_enable_valid, primary_sel_port_b, addr_a9_n); // R4 R5
  assign ctrl_cs_port_c_n  = sel_nand(port_enable_valid, primary_sel_port_c, addr_a9_n); // R4 R5
  assign ctrl_cs_port_d_n  = sel_nand(port_enable_valid, primary_sel_port_d, addr_a9_n); // R4 R5
  assign misc_sel_port_b_n = sel_nand(port_enable_valid, primary_sel_port_b, !addr_a9_n); // R4 R6
  assign misc_sel_port_c_n = sel_nand(port_enable_valid, primary_sel_port_c, !addr_a9_n); // R4 R6
  assign misc_sel_port_d_n = sel_nand(port_enable_valid, primary_sel_port_d, !addr_a9_n); // R4 R6

  // port A upper section, gated by the companion enable
  assign lower_group_enable_n = return_enable_n || !primary_sel_port_a || addr_a9_n; // R7 R8
  assign ctrl_cs_port_a_n     = return_enable_n || !primary_sel_port_a || !addr_a9_n; // R7 R13

  // port A lower section
  assign dialer_out_latch_sel_n = lower_group_enable_n || !(a10 && bit_write_strobe); // R9
  assign dialer_in_mux_sel_n    = lower_group_enable_n || !(a10 && !bit_write_strobe); // R10
  assign modem_in_mux_sel_n     = lower_group_enable_n || !(!a10 && !bit_write_strobe); // R11 R20
  assign led_latch_sel_n        = lower_group_enable_n || !(!a10 && bit_write_strobe); // R12

  // board clear empties the output latches
  assign latch_clear = rst || !io_clear_n; // R19

  cpsd_addr_latch u_led_latch (
    .clk   (clk),
    .clear (latch_clear),
    .sel_n (led_latch_sel_n),
    .index (sub_index),
    .data  (serial_bit_out),
    .q     (port_a_latch)
  );

  cpsd_addr_latch u_dialer_latch (
    .clk   (clk),
    .clear (latch_clear),
    .sel_n (dialer_out_latch_sel_n),
    .index (sub_index),
    .data  (serial_bit_out),
    .q     (dialer_latch)
  );

  assign led_a = port_a_latch[LED_BIT]; // R16
  assign dtr_a = port_a_latch[DTR_BIT]; // R16

  // modem and switch levels for port A
  always_comb begin
    modem_din          = '0;
    modem_din[MUX_DSR] = !modem_dsr_a_n; // R17
    modem_din[MUX_RI]  = !modem_ri_a_n; // R17
    modem_din[MUX_SW0] = switch_data_a[0]; // R17
    modem_din[MUX_SW1] = switch_data_a[1]; // R17
  end

  assign dialer_din = {{(LATCH_W-DIAL_IN_W){1'b0}}, dialer_in};

  cpsd_bit_mux u_modem_mux (
    .din     (modem_din),
    .index   (sub_index),
    .sel_n   (modem_in_mux_sel_n),
    .bit_out (modem_bit)
  );

  cpsd_bit_mux u_dialer_mux (
    .din     (dialer_din),
    .index   (sub_index),
    .sel_n   (dialer_in_mux_sel_n),
    .bit_out (dialer_bit)
  );

  // shared bit-input return path
  always_comb begin
    serial_bit_in = 1'b0;
    if (serial_bit_in_oe) begin // R2
      serial_bit_in = (!ctrl_cs_port_a_n && ctrl_bit_in_a)
                   || (!ctrl_cs_port_b_n && ctrl_bit_in_b)
                   || (!ctrl_cs_port_c_n && ctrl_bit_in_c)
                   || (!ctrl_cs_port_d_n && ctrl_bit_in_d)
                   || (!misc_sel_port_b_n && misc_bit_in_b)
                   || (!misc_sel_port_c_n && misc_bit_in_c)
                   || (!misc_sel_port_d_n && misc_bit_in_d)
                   || modem_bit || dialer_bit; // R17
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_dialer_write;
    !primary_sel_port_b && !primary_sel_port_c && !primary_sel_port_d
      && primary_sel_port_a && !addr_a9_n && a10 && bit_write_strobe && io_clear_n;
  endsequence

  sequence s_led_write;
    primary_sel_port_a && !addr_a9_n && !a10 && bit_write_strobe && io_clear_n;
  endsequence

  a_valid_any: assert property ( // R1
    port_enable_valid == (primary_sel_port_a || primary_sel_port_b
                          || primary_sel_port_c || primary_sel_port_d))
    else $error("enable valid does not follow primary selects");

  a_return_gate: assert property ( // R2
    serial_bit_in_oe == port_enable_valid && return_enable_n == !port_enable_valid)
    else $error("return buffer enable wrong");

  a_idle_quiet: assert property ( // R3
    !port_enable_valid |-> (ctrl_cs_port_b_n && ctrl_cs_port_c_n && ctrl_cs_port_d_n
      && misc_sel_port_b_n && misc_sel_port_c_n && misc_sel_port_d_n
      && lower_group_enable_n && ctrl_cs_port_a_n && !serial_bit_in))
    else $error("select active with no primary select");

  a_misc_cause: assert property ( // R4
    !misc_sel_port_b_n |-> (port_enable_valid && primary_sel_port_b && !addr_a9_n))
    else $error("port B misc select without cause");

  a_ctrl_b_sel: assert property ( // R5
    (primary_sel_port_b && addr_a9_n) |-> (!ctrl_cs_port_b_n && misc_sel_port_b_n))
    else $error("port B controller not selected");

  a_misc_d_sel: assert property ( // R6
    (primary_sel_port_d && !addr_a9_n) |-> (!misc_sel_port_d_n && ctrl_cs_port_d_n))
    else $error("port D misc select missing");

  a_port_a_idle: assert property ( // R7
    !primary_sel_port_a |-> (ctrl_cs_port_a_n && lower_group_enable_n && modem_in_mux_sel_n
      && dialer_in_mux_sel_n && led_latch_sel_n && dialer_out_latch_sel_n))
    else $error("port A select active while idle");

  a_group_enable: assert property ( // R8
    (primary_sel_port_a && !addr_a9_n) |-> !lower_group_enable_n)
    else $error("lower group not enabled");

  a_dialer_write: assert property ( // R9
    s_dialer_write |=> dialer_latch[$past(sub_index)] == $past(serial_bit_out))
    else $error("dialer latch write lost");

  a_dialer_read: assert property ( // R10
    (primary_sel_port_a && !addr_a9_n && a10 && !bit_write_strobe)
      |-> (!dialer_in_mux_sel_n && serial_bit_in == dialer_din[sub_index]))
    else $error("dialer input not returned");

  a_modem_read: assert property ( // R11
    (primary_sel_port_a && !addr_a9_n && !a10 && !bit_write_strobe && sub_index == MUX_DSR)
      |-> (!modem_in_mux_sel_n && serial_bit_in == !modem_dsr_a_n))
    else $error("modem DSR not returned");

  a_led_write: assert property ( // R12
    s_led_write |=> port_a_latch[$past(sub_index)] == $past(serial_bit_out))
    else $error("LED latch write lost");

  a_ctrl_a_sel: assert property ( // R13
    (primary_sel_port_a && addr_a9_n) |-> (!ctrl_cs_port_a_n && lower_group_enable_n))
    else $error("port A controller not selected");

  a_clear_latch: assert property ( // R19
    !io_clear_n |=> (port_a_latch == LATCH_CLEAR && dialer_latch == LATCH_CLEAR))
    else $error("latches not cleared");

  a_one_target: assert property ( // R20
    $onehot0({ctrl_cs_port_a_n, modem_in_mux_sel_n, dialer_in_mux_sel_n,
              led_latch_sel_n, dialer_out_latch_sel_n} ^ 5'h1f))
    else $error("two port A targets at once");

  a_base_match: assert property ( // R18
    primary_sel_port_c == (addr_base == base_sw_c))
    else $error("primary select mismatch");

  a_misc_c_cause: assert property ( // R4
    !misc_sel_port_c_n |-> (port_enable_valid && primary_sel_port_c && !addr_a9_n))
    else $error("port C misc select without cause");

  a_ctrl_d_cause: assert property ( // R4
    !ctrl_cs_port_d_n |-> (port_enable_valid && primary_sel_port_d && addr_a9_n))
    else $error("port D controller select without cause");

  a_ctrl_c_sel: assert property ( // R5
    (primary_sel_port_c && addr_a9_n) |-> (!ctrl_cs_port_c_n && misc_sel_port_c_n))
    else $error("port C controller not selected");

  a_misc_b_sel: assert property ( // R6
    (primary_sel_port_b && !addr_a9_n) |-> (!misc_sel_port_b_n && ctrl_cs_port_b_n))
    else $error("port B misc select missing");

  a_ri_read: assert property ( // R17
    (primary_sel_port_a && !addr_a9_n && !a10 && !bit_write_strobe && sub_index == MUX_RI)
      |-> (serial_bit_in == !modem_ri_a_n))
    else $error("modem RI not returned");

  a_switch_read: assert property ( // R17
    (primary_sel_port_a && !addr_a9_n && !a10 && !bit_write_strobe && sub_index == MUX_SW1)
      |-> (serial_bit_in == switch_data_a[1]))
    else $error("switch level not returned");

  a_dtr_write: assert property ( // R16
    s_led_write |=> ($past(sub_index) != DTR_BIT || dtr_a == $past(serial_bit_out)))
    else $error("DTR output not written");

  a_led_only: assert property ( // R12
    s_led_write |=> $stable(dialer_latch))
    else $error("LED write reached dialer latch");

  a_bit_pass: assert property ( // R14
    ctrl_bit_select == bit_select_lines)
    else $error("controller bit select not passed");
endmodule : cpsd_decoder
`default_nettype wire

/* cpsd_host_model.sv */
// host side of the serial bit bus: address, strobe and write data
// assumes the caller enters access just after a rising clk edge
`default_nettype none
module cpsd_host_model
  import cpsd_pkg::*;
(
  output logic [BASE_W-1:0] addr_base,
  output logic              addr_a9_n,
  output logic [IDX_W-1:0]  bit_select_lines,
  output logic              bit_write_strobe,
  output logic              serial_bit_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    addr_base        = '1;
    addr_a9_n        = 1'b1;
    bit_select_lines = '0;
    bit_write_strobe = 1'b0;
    serial_bit_out   = 1'b0;
  end

  // one bus cycle, held until the next call
  task automatic access(input logic [BASE_W-1:0] b, input logic a9, input logic [IDX_W-1:0] idx,
                        input logic stb, input logic d);
    addr_base        = b;
    addr_a9_n        = a9;
    bit_select_lines = idx;
    bit_write_strobe = stb;
    serial_bit_out   = d;
  endtask : access
endmodule : cpsd_host_model
`default_nettype wire

/* tb_cru_port_select_decoder.sv */
// self-checking bench for the secondary select decoder
// assumes cpsd_pkg, cpsd_decoder and cpsd_host_model are compiled first
`default_nettype none
`define CPSD_CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp); end end
module tb_cru_port_select_decoder
  import cpsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [3:0] ps; logic pev, ren, oe, sbi; logic [IDX_W-1:0] cbs;
    logic [3:0] cs; logic [2:0] ms; logic [4:0] a_sel; logic [LATCH_W-1:0] pal, dll;
  } cpsd_note_t;
  logic clk, rst, clr_n, a9, stb, dout, dsr_n, ri_n, pev, ren, sbi, oe, led_a, dtr_a;
  logic lge, mim, dim, led, dol;
  logic [BASE_W-1:0] ab;
  logic [BASE_W-1:0] sw [4];
  logic [IDX_W-1:0] bsl, cbs;
  logic [3:0] cbi, ps, cs_n;
  logic [2:0] mbi, ms_n;
  logic [SW_W-1:0] swd;
  logic [DIAL_IN_W-1:0] dial;
  logic [LATCH_W-1:0] pal, dll, m_pal, m_dll;
  logic [31:0] r, r2;
  cpsd_note_t q [$];
  cpsd_note_t n;
  int num_errors = 0;
  int comparisons = 0;

  cpsd_host_model i_cpsd_host_model (.addr_base(ab), .addr_a9_n(a9), .bit_select_lines(bsl),
    .bit_write_strobe(stb), .serial_bit_out(dout));
  cpsd_decoder i_cpsd_decoder (.clk(clk), .rst(rst), .io_clear_n(clr_n), .addr_base(ab),
    .addr_a9_n(a9), .bit_select_lines(bsl), .bit_write_strobe(stb), .serial_bit_out(dout),
    .base_sw_a(sw[0]), .base_sw_b(sw[1]), .base_sw_c(sw[2]), .base_sw_d(sw[3]),
    .ctrl_bit_in_a(cbi[0]), .ctrl_bit_in_b(cbi[1]), .ctrl_bit_in_c(cbi[2]), .ctrl_bit_in_d(cbi[3]),
    .misc_bit_in_b(mbi[0]), .misc_bit_in_c(mbi[1]), .misc_bit_in_d(mbi[2]),
    .modem_dsr_a_n(dsr_n), .modem_ri_a_n(ri_n), .switch_data_a(swd), .dialer_in(dial),
    .primary_sel_port_a(ps[0]), .primary_sel_port_b(ps[1]), .primary_sel_port_c(ps[2]),
    .primary_sel_port_d(ps[3]), .port_enable_valid(pev), .return_enable_n(ren),
    .serial_bit_in(sbi), .serial_bit_in_oe(oe), .ctrl_bit_select(cbs),
    .ctrl_cs_port_a_n(cs_n[0]), .ctrl_cs_port_b_n(cs_n[1]), .ctrl_cs_port_c_n(cs_n[2]),
    .ctrl_cs_port_d_n(cs_n[3]), .misc_sel_port_b_n(ms_n[0]), .misc_sel_port_c_n(ms_n[1]),
    .misc_sel_port_d_n(ms_n[2]), .lower_group_enable_n(lge), .modem_in_mux_sel_n(mim),
    .dialer_in_mux_sel_n(dim), .led_latch_sel_n(led), .dialer_out_latch_sel_n(dol),
    .port_a_latch(pal), .dialer_latch(dll), .led_a(led_a), .dtr_a(dtr_a));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // reference copy of both port A latches
  always @(posedge clk) begin
    if (rst || !clr_n) begin
      m_pal <= LATCH_CLEAR;
      m_dll <= LATCH_CLEAR;
    end else if (ab === sw[0] && !a9 && stb) begin
      if (bsl[A10_POS]) m_dll[bsl[2:0]] <= dout;
      else m_pal[bsl[2:0]] <= dout;
    end
  end

  function automatic cpsd_note_t make_note();
    cpsd_note_t e;
    logic sa, a10, mux;
    logic [2:0] ix;
    for (int k = 0; k < 4; k++) e.ps[k] = (ab === sw[k]);
    sa = e.ps[0] && !a9;
    a10 = bsl[A10_POS];
    ix = bsl[2:0];
    e.pev = |e.ps;
    e.ren = !e.pev;
    e.oe = e.pev;
    e.cbs = bsl;
    for (int k = 0; k < 4; k++) e.cs[k] = !(e.ps[k] && a9);
    for (int k = 0; k < 3; k++) e.ms[k] = !(e.pev && e.ps[k+1] && !a9);
    e.a_sel = ~{sa, sa && !stb && !a10, sa && !stb && a10, sa && stb && !a10, sa && stb && a10};
    case (ix)
      MUX_DSR: mux = !dsr_n;
      MUX_RI:  mux = !ri_n;
      MUX_SW0: mux = swd[0];
      MUX_SW1: mux = swd[1];
      default: mux = 1'b0;
    endcase
    e.sbi = e.pev && ((|(cbi & ~e.cs)) || (|(mbi & ~e.ms)) || (!e.a_sel[3] && mux)
            || (!e.a_sel[2] && ix < DIAL_IN_W && dial[ix]));
    e.pal = m_pal;
    e.dll = m_dll;
    return e;
  endfunction : make_note

  // watcher: each note is checked in the low half of its cycle
  always @(negedge clk) begin
    if (q.size() > 0) begin
      n = q.pop_front();
      `CPSD_CHK(ps, n.ps)
      `CPSD_CHK(pev, n.pev)
      `CPSD_CHK({ren, oe}, {n.ren, n.oe})
      `CPSD_CHK(cs_n, n.cs)
      `CPSD_CHK(ms_n, n.ms)
      `CPSD_CHK({lge, mim, dim, led, dol}, n.a_sel)
      `CPSD_CHK(sbi, n.sbi)
      `CPSD_CHK(cbs, n.cbs)
      `CPSD_CHK({pal, dll}, {n.pal, n.dll})
      `CPSD_CHK({led_a, dtr_a}, {n.pal[LED_BIT], n.pal[DTR_BIT]})
    end
  end

  task automatic give_verdict();
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #(2000 * 100);
    num_errors++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    clr_n = 1'b1;
    sw[0] = 6'h08;
    sw[1] = 6'h0a;
    sw[2] = 6'h0c;
    sw[3] = 6'h0e;
    {cbi, mbi, dsr_n, ri_n, swd, dial} = '0;
    void'($urandom(6161));
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      #1;
      r = $urandom;
      r2 = $urandom;
      rst = (i == 250);
      clr_n = !(i > 32 && r2[3:0] == 4'h0);
      {cbi, mbi, dsr_n, ri_n, swd, dial} = r[15:0];
      if (i < 32) begin
        i_cpsd_host_model.access(sw[i % 4], i[2], {i[4], r[19:16]}, i[3], r[20]);
      end else begin
        i_cpsd_host_model.access(r2[4] ? sw[r2[6:5]] : r2[12:7], r2[13], r2[18:14], r2[19], r2[20]);
      end
      q.push_back(make_note());
    end
    repeat (2) @(posedge clk);
    give_verdict();
  end
endmodule : tb_cru_port_select_decoder
`default_nettype wire
